// ==== src/omsq_cfg.svh ====
/*
  timing, offset and field macros of the operating mode sequencer.
  assumes a 40 MHz system clock; times are in microseconds.
*/
`ifndef OMSQ_CFG_SVH
`define OMSQ_CFG_SVH

// ----------------------------------------------------------------------
// clock and times
// ----------------------------------------------------------------------
`define OMSQ_CLK_MHZ 40
`define OMSQ_FIRST_BOOT_US 1000
`define OMSQ_SECOND_BOOT_US 2000
`define OMSQ_HIB_ENTRY_US 1000
`define OMSQ_ASLP_TICK_US 1000
`define OMSQ_FIRST_BOOT_CYC (`OMSQ_FIRST_BOOT_US * `OMSQ_CLK_MHZ)
`define OMSQ_SECOND_BOOT_CYC (`OMSQ_SECOND_BOOT_US * `OMSQ_CLK_MHZ)
`define OMSQ_HIB_ENTRY_CYC (`OMSQ_HIB_ENTRY_US * `OMSQ_CLK_MHZ)
`define OMSQ_ASLP_TICK_CYC (`OMSQ_ASLP_TICK_US * `OMSQ_CLK_MHZ)

// ----------------------------------------------------------------------
// device register offsets and fields
// ----------------------------------------------------------------------
`define OMSQ_AW 4
`define OMSQ_DW 8
`define OMSQ_REG_CTRL_ONE 4'h0
`define OMSQ_REG_CTRL_FOUR 4'h1
`define OMSQ_REG_CTRL_FIVE 4'h2
`define OMSQ_REG_ASLP 4'h3
`define OMSQ_REG_STATUS 4'h4
`define OMSQ_BIT_ACTIVE 0
`define OMSQ_BIT_PIN2_FUNC 0
`define OMSQ_BIT_HIB_EN 0
`define OMSQ_RST_ASLP 8'h00

// ----------------------------------------------------------------------
// host command port offsets and fields
// ----------------------------------------------------------------------
`define OMSQ_HREG_PINS 4'h0
`define OMSQ_HREG_DADDR 4'h1
`define OMSQ_HREG_DWRITE 4'h2
`define OMSQ_HREG_DREAD 4'h3
`define OMSQ_HREG_DRDATA 4'h4
`define OMSQ_HBIT_MOTION 0
`define OMSQ_HBIT_WAKE 1
`define OMSQ_HBIT_TRIG 2

`endif

// ==== src/omsq_dev.sv ====
/*
  device end: operating mode sequencer of the motion sensor.
  assumes host pins synchronous to i_clk; power-on is i_rst_n.
*/
// Implementation choices: the address map and the strobed register port.
// How it works
// - strap low: boot, then standby
// - strap high: boot done with motion high, wake, active set
// - strap low standby: hibernate enable enters hibernate
// - strap high: motion low long forces hibernate
// - strap high: motion rising edge exits hibernate
// - strap low: host toggles wake pin to exit hibernate
// - strap low: pin function one enters trigger
// - strap low: pin function zero returns standby
// - trigger rising edge starts conversion, wake
// - triggered measurement done returns to trigger wait
// - strap high: no external trigger state
// - strap low: active bit moves standby/wake
// - strap high: motion low clears active
// - strap high: host clear enters standby
// - strap high: host set reenters wake
// - auto-sleep timer reaching count enters sleep
// - event in sleep returns to wake
// - strap high: wake pin ignored; hibernate bit enters hibernate from any run state
// - strap high: debounce motion low before hibernate
// - hibernate exit resets all registers
`timescale 1ns/1ps
`include "omsq_cfg.svh"

module omsq_dev
  import omsq_pkg::*;
#(
  parameter int unsigned FIRST_BOOT_CYC = `OMSQ_FIRST_BOOT_CYC,
  parameter int unsigned SECOND_BOOT_CYC = `OMSQ_SECOND_BOOT_CYC,
  parameter int unsigned HIB_ENTRY_CYC = `OMSQ_HIB_ENTRY_CYC,
  parameter int unsigned ASLP_TICK_CYC = `OMSQ_ASLP_TICK_CYC
) (
  // clock and power-on reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // strap and measurement side
  input wire logic i_boot_config_strap,
  input wire logic i_meas_done,
  input wire logic i_aws_event,
  // state and measurement control
  output logic [2:0] o_state,
  output logic o_meas_start,
  output logic o_measuring,
  // link to the host
  omsq_if.dev lnk
);
  // ----------------------------------------------------------------------
  // state and registers
  // ----------------------------------------------------------------------
  omsq_state_t st_q, st_d;
  logic strap_q;
  logic active_q, pin2_q, hib_en_q;
  logic [7:0] auto_sleep_count_q;
  logic [7:0] aslp_tmr_q;
  logic [23:0] boot_cnt_q, deb_cnt_q, tick_cnt_q;
  logic motion_prev_q, wake_prev_q, trig_prev_q;
  logic trig_meas_q;
  logic meas_start_q;
  logic measuring_q;
  logic [`OMSQ_DW-1:0] rdata_q;

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  localparam logic [23:0] BOOT1_LAST = 24'(FIRST_BOOT_CYC - 1);
  localparam logic [23:0] BOOT2_LAST = 24'(SECOND_BOOT_CYC - 1);
  localparam logic [23:0] HIB_LAST = 24'(HIB_ENTRY_CYC - 1);
  localparam logic [23:0] TICK_LAST = 24'(ASLP_TICK_CYC - 1);

  // bus reachable only once booted and out of hibernate
  wire bus_ok = (st_q != OMSQ_BOOT) && (st_q != OMSQ_HIBERNATE);
  wire wr = lnk.reg_we && bus_ok;
  wire wr_one = wr && (lnk.reg_addr == `OMSQ_REG_CTRL_ONE);
  wire wr_four = wr && (lnk.reg_addr == `OMSQ_REG_CTRL_FOUR);
  wire wr_five = wr && (lnk.reg_addr == `OMSQ_REG_CTRL_FIVE);
  wire wr_aslp = wr && (lnk.reg_addr == `OMSQ_REG_ASLP);
  wire [`OMSQ_DW-1:0] rd_mux =
    (lnk.reg_addr == `OMSQ_REG_CTRL_ONE) ? {7'h00, active_q} :
    (lnk.reg_addr == `OMSQ_REG_CTRL_FOUR) ? {7'h00, pin2_q} :
    (lnk.reg_addr == `OMSQ_REG_CTRL_FIVE) ? {7'h00, hib_en_q} :
    (lnk.reg_addr == `OMSQ_REG_ASLP) ? auto_sleep_count_q :
    (lnk.reg_addr == `OMSQ_REG_STATUS) ? {5'h00, st_q} : 8'h00;

  // pin events
  wire motion_rise = lnk.motion_line && !motion_prev_q;
  wire wake_edge = lnk.wake_pin != wake_prev_q;
  wire trig_rise = lnk.trig_pin && !trig_prev_q;
  wire boot_last = strap_q ? (boot_cnt_q == BOOT2_LAST) : (boot_cnt_q == BOOT1_LAST);
  wire booted = strap_q ? (st_q == OMSQ_BOOT) && boot_last && lnk.motion_line
                        : (st_q == OMSQ_BOOT) && boot_last;
  wire in_run = (st_q == OMSQ_STANDBY) || (st_q == OMSQ_WAKE) || (st_q == OMSQ_SLEEP);
  // motion low held for the entry time (strap high only)
  wire hib_motion = strap_q && in_run && !lnk.motion_line && (deb_cnt_q == HIB_LAST);
  wire hib_reg = hib_en_q && (strap_q ? in_run : (st_q == OMSQ_STANDBY));
  wire tick = (tick_cnt_q == TICK_LAST);
  wire aslp_hit = (auto_sleep_count_q != 8'h00) && (aslp_tmr_q >= auto_sleep_count_q);
  wire leave_hib = (st_q == OMSQ_HIBERNATE) && (strap_q ? motion_rise : wake_edge);
  wire clr_regs = leave_hib;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      OMSQ_BOOT: begin
        if (boot_last && strap_q && !lnk.motion_line) st_d = OMSQ_HIBERNATE;
        else if (booted) st_d = strap_q ? OMSQ_WAKE : OMSQ_STANDBY;
      end
      OMSQ_HIBERNATE: begin
        if (strap_q && motion_rise) st_d = OMSQ_BOOT;
        else if (!strap_q && wake_edge) st_d = OMSQ_BOOT;
      end
      OMSQ_STANDBY: begin
        if (hib_motion || hib_reg) st_d = OMSQ_HIBERNATE;
        else if (active_q) st_d = OMSQ_WAKE;
        else if (pin2_q && !strap_q) st_d = OMSQ_EXTERNAL_TRIGGER_STATE;
      end
      OMSQ_EXTERNAL_TRIGGER_STATE: begin
        if (!pin2_q || strap_q) st_d = OMSQ_STANDBY;
        else if (trig_rise) st_d = OMSQ_WAKE;
      end
      OMSQ_WAKE: begin
        if (trig_meas_q) begin
          if (i_meas_done) st_d = OMSQ_EXTERNAL_TRIGGER_STATE;
        end else if (hib_motion || hib_reg) st_d = OMSQ_HIBERNATE;
        else if (!active_q) st_d = OMSQ_STANDBY;
        else if (aslp_hit && !i_aws_event) st_d = OMSQ_SLEEP;
      end
      OMSQ_SLEEP: begin
        if (hib_motion || hib_reg) st_d = OMSQ_HIBERNATE;
        else if (!active_q) st_d = OMSQ_STANDBY;
        else if (i_aws_event) st_d = OMSQ_WAKE;
      end
      default: st_d = OMSQ_BOOT;
    endcase
  end

  // state register and strap capture
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= OMSQ_BOOT;
      strap_q <= 1'b0;
    end else begin
      st_q <= st_d;
      if (st_q == OMSQ_BOOT) strap_q <= i_boot_config_strap;
    end
  end

  // pin history for edge detection
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      motion_prev_q <= 1'b0;
      wake_prev_q <= 1'b0;
      trig_prev_q <= 1'b0;
    end else begin
      motion_prev_q <= lnk.motion_line;
      wake_prev_q <= lnk.wake_pin;
      trig_prev_q <= lnk.trig_pin;
    end
  end

  // boot timer; runs from boot entry to the boot length of the captured strap
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      boot_cnt_q <= 24'h000000;
    end else if (st_q != OMSQ_BOOT || boot_last) begin
      boot_cnt_q <= 24'h000000;
    end else begin
      boot_cnt_q <= boot_cnt_q + 24'h000001;
    end
  end

  // motion low debounce
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      deb_cnt_q <= 24'h000000;
    end else if (!strap_q || !in_run || lnk.motion_line || hib_motion) begin
      deb_cnt_q <= 24'h000000;
    end else begin
      deb_cnt_q <= deb_cnt_q + 24'h000001;
    end
  end

  // auto-sleep tick divider and timer; any event clears the timer
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tick_cnt_q <= 24'h000000;
      aslp_tmr_q <= 8'h00;
    end else begin
      tick_cnt_q <= tick ? 24'h000000 : tick_cnt_q + 24'h000001;
      if (st_q != OMSQ_WAKE || i_aws_event || trig_meas_q) aslp_tmr_q <= 8'h00;
      else if (tick && aslp_tmr_q != 8'hff) aslp_tmr_q <= aslp_tmr_q + 8'h01;
    end
  end

  // control registers; hardware updates win over host writes
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      active_q <= 1'b0;
      pin2_q <= 1'b0;
      hib_en_q <= 1'b0;
      auto_sleep_count_q <= `OMSQ_RST_ASLP;
    end else if (clr_regs) begin
      active_q <= 1'b0;
      pin2_q <= 1'b0;
      hib_en_q <= 1'b0;
      auto_sleep_count_q <= `OMSQ_RST_ASLP;
    end else begin
      if (booted && strap_q) active_q <= 1'b1;
      else if (hib_motion) active_q <= 1'b0;
      else if (wr_one) active_q <= lnk.reg_wdata[`OMSQ_BIT_ACTIVE];
      if (wr_four) pin2_q <= lnk.reg_wdata[`OMSQ_BIT_PIN2_FUNC];
      if (st_d == OMSQ_HIBERNATE) hib_en_q <= 1'b0;
      else if (wr_five) hib_en_q <= lnk.reg_wdata[`OMSQ_BIT_HIB_EN];
      if (wr_aslp) auto_sleep_count_q <= lnk.reg_wdata;
    end
  end

  // triggered conversion tracking and registered measuring flag
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      trig_meas_q <= 1'b0;
      meas_start_q <= 1'b0;
      measuring_q <= 1'b0;
    end else begin
      meas_start_q <= (st_q == OMSQ_EXTERNAL_TRIGGER_STATE) && (st_d == OMSQ_WAKE);
      measuring_q <= (st_d == OMSQ_WAKE) || (st_d == OMSQ_SLEEP);
      if (st_q == OMSQ_EXTERNAL_TRIGGER_STATE && st_d == OMSQ_WAKE) trig_meas_q <= 1'b1;
      else if (st_q == OMSQ_WAKE && st_d != OMSQ_WAKE) trig_meas_q <= 1'b0;
    end
  end

  // register read data, one cycle after the strobe
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= (lnk.reg_re && bus_ok) ? rd_mux : 8'h00;
    end
  end

  assign lnk.reg_rdata = rdata_q;
  assign o_state = st_q;
  assign o_meas_start = meas_start_q;
  assign o_measuring = measuring_q;
endmodule

// ==== src/omsq_host.sv ====
/*
  host controller end: drives the mode pins and the device register port.
  assumes a software master on a plain port with read data one cycle later.
*/
`timescale 1ns/1ps
`include "omsq_cfg.svh"

module omsq_host
  import omsq_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // software command port
  input wire logic [`OMSQ_AW-1:0] i_addr,
  input wire logic [`OMSQ_DW-1:0] i_wdata,
  input wire logic i_we,
  input wire logic i_re,
  output logic [`OMSQ_DW-1:0] o_rdata,
  // link to the device
  omsq_if.host lnk
);
  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  logic [2:0] pins_q;
  logic [`OMSQ_AW-1:0] daddr_q;
  logic [`OMSQ_DW-1:0] dwdata_q;
  logic dwe_q, dre_q, dre_d1_q;
  logic [`OMSQ_DW-1:0] drdata_q;
  logic [`OMSQ_DW-1:0] rdata_q;
  wire wr_pins = i_we && (i_addr == `OMSQ_HREG_PINS);
  wire wr_daddr = i_we && (i_addr == `OMSQ_HREG_DADDR);
  wire wr_dwrite = i_we && (i_addr == `OMSQ_HREG_DWRITE);
  wire wr_dread = i_we && (i_addr == `OMSQ_HREG_DREAD);
  wire [`OMSQ_DW-1:0] rd_mux =
    (i_addr == `OMSQ_HREG_PINS) ? {5'h00, pins_q} :
    (i_addr == `OMSQ_HREG_DADDR) ? {4'h0, daddr_q} :
    (i_addr == `OMSQ_HREG_DRDATA) ? drdata_q : 8'h00;

  // pin levels; with strap high motion low long enough forces hibernate, with strap low wake toggle exits it
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pins_q <= 3'h0;
    end else if (wr_pins) begin
      pins_q <= i_wdata[2:0];
    end
  end

  // device register transfers, one strobe cycle each
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      daddr_q <= 4'h0;
      dwdata_q <= 8'h00;
      dwe_q <= 1'b0;
      dre_q <= 1'b0;
      dre_d1_q <= 1'b0;
      drdata_q <= 8'h00;
    end else begin
      if (wr_daddr) daddr_q <= i_wdata[`OMSQ_AW-1:0];
      if (wr_dwrite) dwdata_q <= i_wdata;
      dwe_q <= wr_dwrite;
      dre_q <= wr_dread && !wr_dwrite;
      dre_d1_q <= dre_q;
      if (dre_d1_q) drdata_q <= lnk.reg_rdata;
    end
  end

  // read data one cycle after the strobe
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= i_re ? rd_mux : 8'h00;
    end
  end

  assign o_rdata = rdata_q;
  assign lnk.motion_line = pins_q[`OMSQ_HBIT_MOTION];
  assign lnk.wake_pin = pins_q[`OMSQ_HBIT_WAKE];
  assign lnk.trig_pin = pins_q[`OMSQ_HBIT_TRIG];
  assign lnk.reg_addr = daddr_q;
  assign lnk.reg_wdata = dwdata_q;
  assign lnk.reg_we = dwe_q;
  assign lnk.reg_re = dre_q;
endmodule

// ==== src/omsq_if.sv ====
/*
  link between the host controller and the sensor mode sequencer.
  assumes one shared clock; all pins are host driven levels except read data.
*/
`timescale 1ns/1ps
`include "omsq_cfg.svh"

interface omsq_if;
  logic motion_line;
  logic wake_pin;
  logic trig_pin;
  logic [`OMSQ_AW-1:0] reg_addr;
  logic [`OMSQ_DW-1:0] reg_wdata;
  logic reg_we;
  logic reg_re;
  logic [`OMSQ_DW-1:0] reg_rdata;

  modport dev (
    input motion_line, wake_pin, trig_pin, reg_addr, reg_wdata, reg_we, reg_re,
    output reg_rdata
  );
  modport host (
    output motion_line, wake_pin, trig_pin, reg_addr, reg_wdata, reg_we, reg_re,
    input reg_rdata
  );
endinterface

// ==== src/omsq_pkg.sv ====
/*
  types of the operating mode sequencer.
  assumes nothing beyond the cfg header.
*/
package omsq_pkg;
  // operating states of the device
  typedef enum logic [2:0] {
    OMSQ_BOOT,
    OMSQ_STANDBY,
    OMSQ_HIBERNATE,
    OMSQ_EXTERNAL_TRIGGER_STATE,
    OMSQ_WAKE,
    OMSQ_SLEEP
  } omsq_state_t;
endpackage

// ==== tb/omsq_props.sv ====
/*
  concurrent checks on the sequencer link and the device state outputs.
  assumes one clock; the bench instantiates it beside the interface.
*/
`timescale 1ns/1ps
`include "omsq_cfg.svh"

module omsq_props
  import omsq_pkg::*;
#(
  parameter int unsigned FIRST_BOOT_CYC = 8,
  parameter int unsigned HIB_ENTRY_CYC = 8
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // device side
  input wire logic i_boot_config_strap,
  input wire logic i_aws_event,
  input wire logic [2:0] o_state,
  input wire logic o_meas_start,
  input wire logic o_measuring,
  // link
  input wire logic motion_line,
  input wire logic trig_pin
);
  // ------------------------------------------------------------------
  // helper counters
  // ------------------------------------------------------------------
  logic [7:0] boot_cnt_q;
  logic [7:0] low_cnt_q;
  wire run_st = o_state == OMSQ_STANDBY || o_state == OMSQ_WAKE || o_state == OMSQ_SLEEP;

  // cycles in boot, and consecutive motion-low cycles in a run state
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      boot_cnt_q <= 8'h00;
      low_cnt_q <= 8'h00;
    end else begin
      boot_cnt_q <= (o_state == OMSQ_BOOT) ? boot_cnt_q + 8'h01 : 8'h00;
      low_cnt_q <= (run_st && !motion_line) ? low_cnt_q + 8'h01 : 8'h00;
    end
  end

  // ------------------------------------------------------------------
  // properties
  // ------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  boot_len_a: assert property (!i_boot_config_strap && o_state == OMSQ_BOOT
    |-> boot_cnt_q <= FIRST_BOOT_CYC + 2) else $error("boot too long");
  boot_exit_a: assert property (!i_boot_config_strap && $past(o_state) == OMSQ_BOOT
    && o_state != OMSQ_BOOT |-> o_state == OMSQ_STANDBY) else $error("bad boot exit");
  boot_wake_a: assert property (i_boot_config_strap && motion_line
    && $past(o_state) == OMSQ_BOOT && o_state != OMSQ_BOOT |-> o_state == OMSQ_WAKE)
    else $error("strap high boot did not wake");
  hib_hold_a: assert property (i_boot_config_strap && o_state == OMSQ_HIBERNATE
    && !motion_line |=> o_state == OMSQ_HIBERNATE) else $error("left hibernate early");
  hib_exit_a: assert property (i_boot_config_strap && o_state == OMSQ_HIBERNATE
    && $rose(motion_line) |-> ##[1:2] o_state == OMSQ_BOOT) else $error("no exit");
  hib_debounce_a: assert property (i_boot_config_strap && run_st
    |-> low_cnt_q <= HIB_ENTRY_CYC + 3) else $error("motion low ignored");
  trig_wake_a: assert property (o_state == OMSQ_EXTERNAL_TRIGGER_STATE && $rose(trig_pin)
    |-> ##[1:2] o_state == OMSQ_WAKE) else $error("trigger missed");
  meas_start_a: assert property ((o_state == OMSQ_EXTERNAL_TRIGGER_STATE) ##1 (o_state == OMSQ_WAKE)
    |-> ##[0:1] o_meas_start) else $error("no conversion start");
  start_pulse_a: assert property (o_meas_start |=> !o_meas_start)
    else $error("start pulse too long");
  no_trig_a: assert property (i_boot_config_strap |-> o_state != OMSQ_EXTERNAL_TRIGGER_STATE)
    else $error("trigger state with strap high");
  sleep_exit_a: assert property (o_state == OMSQ_SLEEP && i_aws_event
    |-> ##[1:2] o_state == OMSQ_WAKE) else $error("sleep not left");
  measuring_a: assert property (o_measuring == (o_state == OMSQ_WAKE
    || o_state == OMSQ_SLEEP)) else $error("measuring flag wrong");

  // scenario covers
  sleep_c: cover property (o_state == OMSQ_WAKE ##1 o_state == OMSQ_SLEEP);
  trig_c: cover property (o_meas_start);
  hib_c: cover property (o_state == OMSQ_HIBERNATE ##1 o_state == OMSQ_BOOT);
endmodule

// ==== tb/tb.sv ====
/*
  bench joining host and device ends through the link interface.
  assumes the software port map and timing of the host end.
*/
`timescale 1ns/1ps
`include "omsq_cfg.svh"

`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_fail++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end

module tb
  import omsq_pkg::*;
;
  // ------------------------------------------------------------------
  // signals and instances
  // ------------------------------------------------------------------
  localparam int unsigned FB = 8;
  localparam int unsigned SB = 16;
  localparam int unsigned HE = 8;
  localparam int unsigned AT = 4;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic strap = 1'b0;
  logic meas_done = 1'b0;
  logic aws_event = 1'b0;
  logic i_we = 1'b0;
  logic i_re = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic [7:0] o_rdata;
  logic [2:0] o_state;
  logic o_meas_start;
  logic o_measuring;
  int n_fail = 0;
  int samples_checked = 0;
  int cyc = 0;

  omsq_if lnk ();
  omsq_host u_omsq_host (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_we(i_we), .i_re(i_re), .o_rdata(o_rdata), .lnk(lnk.host));
  omsq_dev #(.FIRST_BOOT_CYC(FB), .SECOND_BOOT_CYC(SB), .HIB_ENTRY_CYC(HE),
    .ASLP_TICK_CYC(AT)) u_omsq_dev (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_boot_config_strap(strap), .i_meas_done(meas_done), .i_aws_event(aws_event),
    .o_state(o_state), .o_meas_start(o_meas_start), .o_measuring(o_measuring),
    .lnk(lnk.dev));
  omsq_props #(.FIRST_BOOT_CYC(FB), .HIB_ENTRY_CYC(HE)) u_omsq_props (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .i_boot_config_strap(strap), .i_aws_event(aws_event),
    .o_state(o_state), .o_meas_start(o_meas_start), .o_measuring(o_measuring),
    .motion_line(lnk.motion_line), .trig_pin(lnk.trig_pin));

  // clock and hang guard
  initial begin
    forever #12.5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_fail++;
      conclude();
    end
  end

  // ------------------------------------------------------------------
  // access tasks
  // ------------------------------------------------------------------
  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic hw(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_we <= 1'b1;
    @(posedge i_clk);
    i_we <= 1'b0;
  endtask

  task automatic hr(input logic [3:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_addr <= a;
    i_re <= 1'b1;
    @(posedge i_clk);
    i_re <= 1'b0;
    #1;
    `CHK(o_rdata, e)
  endtask

  // device register write and read through the host map
  task automatic dwr(input logic [3:0] a, input logic [7:0] d);
    hw(4'h1, {4'h0, a});
    hw(4'h2, d);
    repeat (3) @(posedge i_clk);
  endtask

  task automatic drd(input logic [3:0] a, input logic [7:0] e);
    hw(4'h1, {4'h0, a});
    hw(4'h3, 8'h00);
    repeat (4) @(posedge i_clk);
    hr(4'h4, e);
  endtask

  // pins: bit0 motion, bit1 wake, bit2 trigger
  task automatic pin(input logic [2:0] p);
    hw(4'h0, {5'h00, p});
  endtask

  task automatic wst(input logic [2:0] s, input int n);
    #1;
    repeat (n) begin
      if (o_state === s) break;
      @(posedge i_clk);
      #1;
    end
    `CHK(o_state, s)
  endtask

  task automatic hold(input logic [2:0] s, input int n);
    repeat (n) @(posedge i_clk);
    #1;
    `CHK(o_state, s)
  endtask

  // one-cycle measurement-done pulse from the sensor core side
  task automatic done_pulse();
    @(posedge i_clk);
    meas_done <= 1'b1;
    @(posedge i_clk);
    meas_done <= 1'b0;
  endtask

  task automatic rst(input logic s);
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    strap <= s;
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
  endtask

  // one triggered conversion and its return
  task automatic trig();
    pin(3'b000);
    pin(3'b100);
    wst(OMSQ_WAKE, 4);
    `CHK(o_meas_start, 1'b1)
    `CHK(o_measuring, 1'b1)
    done_pulse();
    wst(OMSQ_EXTERNAL_TRIGGER_STATE, 4);
    `CHK(o_measuring, 1'b0)
  endtask

  // ------------------------------------------------------------------
  // tests
  // ------------------------------------------------------------------
  initial begin
    // register-driven scheme
    rst(1'b0);
    wst(OMSQ_STANDBY, FB + 6);
    dwr(4'h3, 8'h02);
    dwr(4'h0, 8'h01);
    wst(OMSQ_WAKE, 4);
    wst(OMSQ_SLEEP, 3 * AT + 6);
    @(posedge i_clk);
    aws_event <= 1'b1;
    wst(OMSQ_WAKE, 4);
    hold(OMSQ_WAKE, 3 * AT + 6);
    dwr(4'h3, 8'h00);
    aws_event <= 1'b0;
    drd(4'h4, {5'h00, OMSQ_WAKE});
    dwr(4'h0, 8'h00);
    wst(OMSQ_STANDBY, 4);
    dwr(4'h1, 8'h01);
    wst(OMSQ_EXTERNAL_TRIGGER_STATE, 4);
    trig();
    trig();
    pin(3'b000);
    dwr(4'h1, 8'h00);
    wst(OMSQ_STANDBY, 4);
    drd(4'h9, 8'h00);
    hr(4'hf, 8'h00);
    dwr(4'h3, 8'h05);
    dwr(4'h2, 8'h01);
    wst(OMSQ_HIBERNATE, 4);
    pin(3'b001);
    hold(OMSQ_HIBERNATE, 6);
    pin(3'b011);
    wst(OMSQ_BOOT, 4);
    wst(OMSQ_STANDBY, FB + 6);
    drd(4'h3, 8'h00);
    // motion-line scheme
    rst(1'b1);
    wst(OMSQ_HIBERNATE, SB + 6);
    pin(3'b001);
    wst(OMSQ_BOOT, 4);
    wst(OMSQ_WAKE, SB + 6);
    drd(4'h0, 8'h01);
    dwr(4'h0, 8'h00);
    wst(OMSQ_STANDBY, 4);
    dwr(4'h1, 8'h01);
    hold(OMSQ_STANDBY, 6);
    dwr(4'h0, 8'h01);
    wst(OMSQ_WAKE, 4);
    pin(3'b000);
    hold(OMSQ_WAKE, HE - 2);
    wst(OMSQ_HIBERNATE, 8);
    hold(OMSQ_HIBERNATE, 6);
    pin(3'b001);
    wst(OMSQ_BOOT, 4);
    wst(OMSQ_WAKE, SB + 6);
    drd(4'h1, 8'h00);
    dwr(4'h2, 8'h01);
    wst(OMSQ_HIBERNATE, 4);
    pin(3'b011);
    hold(OMSQ_HIBERNATE, 6);
    pin(3'b010);
    pin(3'b011);
    wst(OMSQ_BOOT, 4);
    conclude();
  end
endmodule
